// *** src/jtd_core.sv ***
// Data-register side of a four-bit-instruction test port with reset forcing.
// Assumes test pins are asynchronous and sampled by SYS_CLK at 10 MHz.
`timescale 1ns/1ps
module jtd_core #(
  parameter int STRETCH_CYCLES = jtd_pkg::STRETCH_CYCLES
) (
  input wire logic SYS_CLK,
  input wire logic SYS_RST,
  input wire logic CE,
  input wire logic TCK,
  input wire logic TMS,
  input wire logic TDI,
  input wire logic TRST_N,
  output logic TDO,
  output logic TDO_OE,
  output logic VCC_RESET_FORCE,
  output logic VTR_POR_FORCE,
  input wire logic CPU_RESET_REQ,
  output logic CPU_RESET_OUT,
  output logic CPU_RESET_SHORTEN,
  input wire logic [jtd_pkg::CHAIN_W-1:0] PIN_CHAIN_IN,
  output logic PIN_FUNC_DISCONNECT,
  output logic PIN_CHAIN_RESULT_PIN,
  output logic PIN_CHAIN_RESULT_OE
);

  typedef struct packed {
    logic [2:0] tck_s;
    logic [2:0] tms_s;
    logic [2:0] tdi_s;
    logic [2:0] trst_s;
    logic tck_v;
    logic tms_v;
    logic tdi_v;
    logic trst_v;
    logic [2:0][jtd_pkg::CHAIN_W-1:0] pin_s;
    logic [jtd_pkg::CHAIN_W-1:0] pin_v;
    logic [jtd_pkg::IR_W-1:0] ir;
    logic [jtd_pkg::IR_W-1:0] ir_sr;
    logic [jtd_pkg::DR_W-1:0] dr_sr;
    logic [jtd_pkg::DR_W-1:0] rc;
    logic [jtd_pkg::DR_W-1:0] sh;
    logic tdo;
    logic tdo_oe;
    logic chain_on;
    logic chain_out;
    logic vcc_f;
    logic vtr_f;
    jtd_pkg::jtd_cnt_t cnt;
    logic cpu_rst;
  } jtd_core_reg_t;

  jtd_core_reg_t r_q;
  jtd_core_reg_t r_d;
  logic tck_rise;
  logic tck_fall;

  jtd_tap_if tap ();

  // Stable level: follows once second and third stages agree
  function automatic logic agree(input logic [2:0] s, input logic v);
    agree = (s[1] == s[2]) ? s[2] : v;
  endfunction : agree

  // Update only writable bits
  function automatic logic [jtd_pkg::DR_W-1:0] merge(
    input logic [jtd_pkg::DR_W-1:0] old_v,
    input logic [jtd_pkg::DR_W-1:0] new_v,
    input logic [jtd_pkg::DR_W-1:0] ro
  );
    merge = (old_v & ro) | (new_v & ~ro);
  endfunction : merge

  // Test clock edges seen through the synchroniser
  assign tck_rise = ~r_q.tck_v & r_q.tck_s[1] & r_q.tck_s[2];
  assign tck_fall = r_q.tck_v & ~r_q.tck_s[1] & ~r_q.tck_s[2];

  // Controller link
  assign tap.tck_rise = tck_rise;
  assign tap.tms = r_q.tms_v;
  assign tap.trst = ~r_q.trst_v;
  assign tap.halt = r_q.chain_on;

  jtd_tap jtd_tap_i (
    .clk(SYS_CLK),
    .rst(SYS_RST),
    .ce(CE),
    .tap(tap.ctl)
  );

  // Next-state logic
  always_comb
  begin
    r_d = r_q;
    // Pin synchronisers
    r_d.tck_s = {r_q.tck_s[1:0], TCK};
    r_d.tms_s = {r_q.tms_s[1:0], TMS};
    r_d.tdi_s = {r_q.tdi_s[1:0], TDI};
    r_d.trst_s = {r_q.trst_s[1:0], TRST_N};
    r_d.tck_v = agree(r_q.tck_s, r_q.tck_v);
    r_d.tms_v = agree(r_q.tms_s, r_q.tms_v);
    r_d.tdi_v = agree(r_q.tdi_s, r_q.tdi_v);
    r_d.trst_v = agree(r_q.trst_s, r_q.trst_v);
    r_d.pin_s = {r_q.pin_s[1:0], PIN_CHAIN_IN};
    for (int i = 0; i < jtd_pkg::CHAIN_W; i++)
    begin
      if (r_q.pin_s[1][i] == r_q.pin_s[2][i])
        r_d.pin_v[i] = r_q.pin_s[2][i];
    end
    // Chain result: all low reads high, any single toggle inverts
    r_d.chain_out = ~^r_q.pin_v;
    // Forced resets, gated by the enable bit
    r_d.vcc_f = r_q.rc[jtd_pkg::RC_EN_BIT] & ~r_q.rc[jtd_pkg::RC_VCC_BIT];
    r_d.vtr_f = r_q.rc[jtd_pkg::RC_EN_BIT] & ~r_q.rc[jtd_pkg::RC_VTR_BIT];
    // Processor reset stretcher, nominal or shortened length
    if (CPU_RESET_REQ)
      r_d.cnt = r_q.sh[jtd_pkg::SH_FAST_BIT] ? jtd_pkg::jtd_cnt_t'(jtd_pkg::SHORT_CYCLES)
                                            : jtd_pkg::jtd_cnt_t'(STRETCH_CYCLES);
    else if (r_q.cnt != '0)
      r_d.cnt = r_q.cnt - jtd_pkg::jtd_cnt_t'(1);
    r_d.cpu_rst = CPU_RESET_REQ | (r_q.cnt != '0);
    // Reset state selects identification
    if (tap.state == jtd_pkg::TS_TLR)
      r_d.ir = jtd_pkg::IR_IDCODE;
    // Rising test clock: capture, shift, update
    if (tck_rise && !r_q.chain_on)
    begin
      case (tap.state)
        jtd_pkg::TS_CAPIR: r_d.ir_sr = jtd_pkg::IR_CAPTURE;
        jtd_pkg::TS_SHIR: r_d.ir_sr = {r_q.tdi_v, r_q.ir_sr[jtd_pkg::IR_W-1:1]};
        jtd_pkg::TS_UPIR: r_d.ir = r_q.ir_sr;
        jtd_pkg::TS_CAPDR:
        begin
          case (r_q.ir)
            jtd_pkg::IR_RESET_CTRL: r_d.dr_sr = r_q.rc;
            jtd_pkg::IR_SHORTEN: r_d.dr_sr = r_q.sh;
            jtd_pkg::IR_IDCODE: r_d.dr_sr = jtd_pkg::IDCODE_VALUE;
            default: r_d.dr_sr = '0;
          endcase
        end
        jtd_pkg::TS_SHDR:
        begin
          case (r_q.ir)
            jtd_pkg::IR_RESET_CTRL, jtd_pkg::IR_SHORTEN, jtd_pkg::IR_IDCODE:
              r_d.dr_sr = {r_q.tdi_v, r_q.dr_sr[jtd_pkg::DR_W-1:1]};
            default: r_d.dr_sr[0] = r_q.tdi_v;
          endcase
        end
        jtd_pkg::TS_UPDR:
        begin
          case (r_q.ir)
            jtd_pkg::IR_RESET_CTRL:
              r_d.rc = merge(r_q.rc, r_q.dr_sr, jtd_pkg::RESET_CTRL_RO);
            jtd_pkg::IR_SHORTEN:
            begin
              r_d.sh = merge(r_q.sh, r_q.dr_sr, jtd_pkg::SHORTEN_RO);
              if (r_q.dr_sr[jtd_pkg::SH_CHAIN_BIT])
                r_d.chain_on = 1'b1;
            end
            default: r_d.dr_sr = r_q.dr_sr;
          endcase
        end
        default: r_d.ir_sr = r_q.ir_sr;
      endcase
    end
    // Falling test clock: present LSB while shifting, float otherwise
    if (tck_fall)
    begin
      r_d.tdo_oe = (tap.state == jtd_pkg::TS_SHDR) || (tap.state == jtd_pkg::TS_SHIR);
      r_d.tdo = (tap.state == jtd_pkg::TS_SHIR) ? r_q.ir_sr[0] : r_q.dr_sr[0];
    end
    // Test reset clears registers but not chain mode
    if (!r_q.trst_v)
    begin
      r_d.rc = jtd_pkg::RESET_CTRL_RST;
      r_d.sh = jtd_pkg::SHORTEN_RST;
    end
    // Chain mode: test port silenced until power cycle
    if (r_q.chain_on)
      r_d.tdo_oe = 1'b0;
  end

  // State register; SYS_RST stands for power cycle
  always_ff @(posedge SYS_CLK)
  begin
    if (SYS_RST)
      r_q <= '0;
    else if (CE)
      r_q <= r_d;
  end

  // Outputs
  assign TDO = r_q.tdo;
  assign TDO_OE = r_q.tdo_oe;
  assign VCC_RESET_FORCE = r_q.vcc_f;
  assign VTR_POR_FORCE = r_q.vtr_f;
  assign CPU_RESET_OUT = r_q.cpu_rst;
  assign CPU_RESET_SHORTEN = r_q.sh[jtd_pkg::SH_FAST_BIT];
  assign PIN_FUNC_DISCONNECT = r_q.chain_on;
  assign PIN_CHAIN_RESULT_PIN = r_q.chain_out;
  assign PIN_CHAIN_RESULT_OE = r_q.chain_on;

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (SYS_RST);

  // Bypass capture yields a zero cell
  property p_bypass_zero;
    CE && tck_rise && !r_q.chain_on && tap.state == jtd_pkg::TS_CAPDR
      && r_q.ir == jtd_pkg::IR_BYPASS |=> r_q.dr_sr[0] == 1'b0;
  endproperty
  a_bypass_zero: assert property (p_bypass_zero) else $error("bypass capture not zero");

  property p_vcc_force;
    CE && r_q.rc[jtd_pkg::RC_EN_BIT] && !r_q.rc[jtd_pkg::RC_VCC_BIT] |=> VCC_RESET_FORCE;
  endproperty
  a_vcc_force: assert property (p_vcc_force) else $error("main-rail reset not forced");

  property p_vtr_force;
    CE && r_q.rc[jtd_pkg::RC_EN_BIT] && !r_q.rc[jtd_pkg::RC_VTR_BIT] |=> VTR_POR_FORCE;
  endproperty
  a_vtr_force: assert property (p_vtr_force) else $error("standby reset not forced");

  property p_en_gate;
    CE && !r_q.rc[jtd_pkg::RC_EN_BIT] |=> !VCC_RESET_FORCE && !VTR_POR_FORCE;
  endproperty
  a_en_gate: assert property (p_en_gate) else $error("forced reset without enable");

  property p_rc_ro;
    r_q.rc[12:10] == 3'h0;
  endproperty
  a_rc_ro: assert property (p_rc_ro) else $error("read-only reset control bits written");

  property p_sh_ro;
    (r_q.sh & jtd_pkg::SHORTEN_RO) == '0;
  endproperty
  a_sh_ro: assert property (p_sh_ro) else $error("read-only second register bits written");

  property p_chain_sticky;
    r_q.chain_on |=> r_q.chain_on && !TDO_OE;
  endproperty
  a_chain_sticky: assert property (p_chain_sticky) else $error("chain mode left");

  property p_tlr_ir;
    CE && tap.state == jtd_pkg::TS_TLR |=> r_q.ir == jtd_pkg::IR_IDCODE;
  endproperty
  a_tlr_ir: assert property (p_tlr_ir) else $error("reset state did not select identification");

  property p_chain_low_high;
    CE && r_q.chain_on && r_q.pin_v == '0 |=> PIN_CHAIN_RESULT_PIN;
  endproperty
  a_chain_low_high: assert property (p_chain_low_high) else $error("chain not high with inputs low");

  property p_stretch;
    CE && $fell(CPU_RESET_REQ) && !r_q.sh[jtd_pkg::SH_FAST_BIT] ##0 CE [*8] |-> CPU_RESET_OUT;
  endproperty
  a_stretch: assert property (p_stretch) else $error("processor reset not stretched");

  c_bypass: cover property (tck_rise && tap.state == jtd_pkg::TS_SHDR && r_q.ir == jtd_pkg::IR_BYPASS);
  c_rc_update: cover property (tck_rise && tap.state == jtd_pkg::TS_UPDR
    && r_q.ir == jtd_pkg::IR_RESET_CTRL);
  c_chain: cover property ($rose(r_q.chain_on));
  c_force: cover property ($rose(VCC_RESET_FORCE));

endmodule : jtd_core

// *** src/jtd_pkg.sv ***
// Constants, register layouts and types for the test data register block.
// Assumes a 10 MHz system clock that oversamples the test port pins.
package jtd_pkg;

  // Instruction and data register widths
  localparam int IR_W = 4;
  localparam int DR_W = 32;

  // Instruction codes
  localparam logic [IR_W-1:0] IR_RESET_CTRL = 4'h2;
  localparam logic [IR_W-1:0] IR_SHORTEN = 4'hd;
  localparam logic [IR_W-1:0] IR_IDCODE = 4'hc;
  localparam logic [IR_W-1:0] IR_BYPASS = 4'hf;
  localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;

  // Identification value, arbitrary: bit 0 set, low 12 bits not 0ff
  localparam logic [DR_W-1:0] IDCODE_VALUE = 32'h0a5a_5001;

  // Reset values and read-only masks of the two test data registers
  localparam logic [DR_W-1:0] RESET_CTRL_RST = 32'h0000_0000;
  localparam logic [DR_W-1:0] SHORTEN_RST = 32'h0000_0000;
  localparam logic [DR_W-1:0] RESET_CTRL_RO = 32'h0000_1c00;
  localparam logic [DR_W-1:0] SHORTEN_RO = 32'hffc0_30e0;

  // Field positions
  localparam int RC_VCC_BIT = 1;
  localparam int RC_VTR_BIT = 2;
  localparam int RC_EN_BIT = 3;
  localparam int SH_FAST_BIT = 0;
  localparam int SH_CHAIN_BIT = 1;

  // Pin-contact chain width
  localparam int CHAIN_W = 8;

  // Processor reset stretch timing
  localparam int CLK_HZ = 10_000_000;
  localparam int STRETCH_TIME_MS = 20;
  localparam int STRETCH_CYCLES = STRETCH_TIME_MS * (CLK_HZ / 1000);
  localparam int SHORT_TIME_US = 100;
  localparam int SHORT_CYCLES = SHORT_TIME_US * (CLK_HZ / 1_000_000);
  localparam int CNT_W = 18;
  typedef logic [CNT_W-1:0] jtd_cnt_t;

  // Test port controller states
  typedef enum logic [15:0] {
    TS_TLR = 16'h0001,
    TS_RTI = 16'h0002,
    TS_SELDR = 16'h0004,
    TS_CAPDR = 16'h0008,
    TS_SHDR = 16'h0010,
    TS_EX1DR = 16'h0020,
    TS_PADR = 16'h0040,
    TS_EX2DR = 16'h0080,
    TS_UPDR = 16'h0100,
    TS_SELIR = 16'h0200,
    TS_CAPIR = 16'h0400,
    TS_SHIR = 16'h0800,
    TS_EX1IR = 16'h1000,
    TS_PAIR = 16'h2000,
    TS_EX2IR = 16'h4000,
    TS_UPIR = 16'h8000
  } jtd_tap_t;

endpackage : jtd_pkg

// *** src/jtd_tap_if.sv ***
// Link between the sampling core and the test port controller.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
interface jtd_tap_if;
  logic tck_rise;
  logic tms;
  logic trst;
  logic halt;
  jtd_pkg::jtd_tap_t state;

  modport ctl (input tck_rise, input tms, input trst, input halt, output state);
  modport usr (output tck_rise, output tms, output trst, output halt, input state);
endinterface : jtd_tap_if

// *** src/jtd_tap.sv ***
// Test port controller state machine, stepped on sampled test clock rises.
// Assumes the core supplies stable TMS and a rise strobe of one cycle.
`timescale 1ns/1ps
module jtd_tap (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  jtd_tap_if.ctl tap
);

  typedef struct packed {
    jtd_pkg::jtd_tap_t st;
  } jtd_tap_reg_t;

  jtd_tap_reg_t r_q;
  jtd_tap_reg_t r_d;

  // Next state from current state and TMS
  function automatic jtd_pkg::jtd_tap_t tap_next(input jtd_pkg::jtd_tap_t s, input logic m);
    case (s)
      jtd_pkg::TS_TLR: tap_next = m ? jtd_pkg::TS_TLR : jtd_pkg::TS_RTI;
      jtd_pkg::TS_RTI: tap_next = m ? jtd_pkg::TS_SELDR : jtd_pkg::TS_RTI;
      jtd_pkg::TS_SELDR: tap_next = m ? jtd_pkg::TS_SELIR : jtd_pkg::TS_CAPDR;
      jtd_pkg::TS_CAPDR: tap_next = m ? jtd_pkg::TS_EX1DR : jtd_pkg::TS_SHDR;
      jtd_pkg::TS_SHDR: tap_next = m ? jtd_pkg::TS_EX1DR : jtd_pkg::TS_SHDR;
      jtd_pkg::TS_EX1DR: tap_next = m ? jtd_pkg::TS_UPDR : jtd_pkg::TS_PADR;
      jtd_pkg::TS_PADR: tap_next = m ? jtd_pkg::TS_EX2DR : jtd_pkg::TS_PADR;
      jtd_pkg::TS_EX2DR: tap_next = m ? jtd_pkg::TS_UPDR : jtd_pkg::TS_SHDR;
      jtd_pkg::TS_UPDR: tap_next = m ? jtd_pkg::TS_SELDR : jtd_pkg::TS_RTI;
      jtd_pkg::TS_SELIR: tap_next = m ? jtd_pkg::TS_TLR : jtd_pkg::TS_CAPIR;
      jtd_pkg::TS_CAPIR: tap_next = m ? jtd_pkg::TS_EX1IR : jtd_pkg::TS_SHIR;
      jtd_pkg::TS_SHIR: tap_next = m ? jtd_pkg::TS_EX1IR : jtd_pkg::TS_SHIR;
      jtd_pkg::TS_EX1IR: tap_next = m ? jtd_pkg::TS_UPIR : jtd_pkg::TS_PAIR;
      jtd_pkg::TS_PAIR: tap_next = m ? jtd_pkg::TS_EX2IR : jtd_pkg::TS_PAIR;
      jtd_pkg::TS_EX2IR: tap_next = m ? jtd_pkg::TS_UPIR : jtd_pkg::TS_SHIR;
      jtd_pkg::TS_UPIR: tap_next = m ? jtd_pkg::TS_SELDR : jtd_pkg::TS_RTI;
      default: tap_next = jtd_pkg::TS_TLR;
    endcase
  endfunction : tap_next

  // Test reset forces reset state; chain mode freezes the controller
  always_comb
  begin
    r_d = r_q;
    if (tap.trst)
      r_d.st = jtd_pkg::TS_TLR;
    else if (tap.tck_rise && !tap.halt)
      r_d.st = tap_next(r_q.st, tap.tms);
  end

  // State register
  always_ff @(posedge clk)
  begin
    if (rst)
      r_q <= '{st: jtd_pkg::TS_TLR};
    else if (ce)
      r_q <= r_d;
  end

  assign tap.state = r_q.st;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_trst_tlr;
    ce && tap.trst |=> r_q.st == jtd_pkg::TS_TLR;
  endproperty
  a_trst_tlr: assert property (p_trst_tlr) else $error("test reset did not reach reset state");

endmodule : jtd_tap

// *** verif/jtd_host_model.sv ***
// Test port host model: drives test clock, mode select and serial data in.
// Assumes the block oversamples the pins with a 10 MHz clock; test clock period 800 ns.
`timescale 1ns/1ps
module jtd_host_model (
  input wire logic clk,
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo,
  input wire logic tdo_oe
);
  logic shift_oe;

  // Idle pins: clock stands high between scans
  initial
  begin
    tck = 1'b1;
    tms = 1'b1;
    tdi = 1'b0;
    shift_oe = 1'b0;
  end

  // One test clock period of 8 system clocks; data out taken after the rise
  task automatic step(input logic m, input logic d, output logic q);
    @(negedge clk);
    tck = 1'b0;
    tms = m;
    tdi = d;
    repeat (4) @(negedge clk);
    tck = 1'b1;
    repeat (2) @(negedge clk);
    // A released data line reads as the inverse of its last level
    q = tdo_oe ? tdo : ~tdo;
    shift_oe = shift_oe | tdo_oe;
    @(negedge clk);
  endtask : step

  // Idle or reset state through capture, n shifts LSB first, update, back to idle
  task automatic scan(input logic ir, input logic [39:0] din, input int n,
                      output logic [39:0] dout);
    logic q;
    dout = '0;
    shift_oe = 1'b0;
    step(1'b0, 1'b0, q);
    step(1'b1, 1'b0, q);
    if (ir)
      step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
    step(1'b0, 1'b0, q);
    for (int i = 0; i < n; i++)
    begin
      step(i == n - 1, din[i], q);
      dout[i] = q;
    end
    step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
    // Update lands after the sampled rise; let it reach the registers
    repeat (2) @(negedge clk);
  endtask : scan

  // Chain discovery: reset, then data scan of eight ones and zeros after
  task automatic discover(output logic [39:0] dout);
    logic q;
    repeat (5) step(1'b1, 1'b0, q);
    scan(1'b0, 40'h00_0000_00ff, 40, dout);
  endtask : discover
endmodule : jtd_host_model

// *** verif/tb_jtd_core.sv ***
// Testbench for the test data register block, driven through the test port host model.
// Assumes the host model beside it and a 10 MHz system clock.
`timescale 1ns/1ps
module tb_jtd_core;
  localparam int STRETCH = 2000;
  localparam int SHORT = jtd_pkg::SHORT_CYCLES;
  logic SYS_CLK, SYS_RST, CE, TCK, TMS, TDI, TRST_N, TDO, TDO_OE;
  logic VCC_RESET_FORCE, VTR_POR_FORCE, CPU_RESET_REQ, CPU_RESET_OUT, CPU_RESET_SHORTEN;
  logic [7:0] PIN_CHAIN_IN;
  logic PIN_FUNC_DISCONNECT, PIN_CHAIN_RESULT_PIN, PIN_CHAIN_RESULT_OE;
  logic [39:0] d;
  logic [2:0] v;
  logic exp;
  int idx;
  int errors = 0;
  int comparisons = 0;

  jtd_core #(.STRETCH_CYCLES(STRETCH)) jtd_core_i (
    .SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST), .CE(CE), .TCK(TCK), .TMS(TMS), .TDI(TDI),
    .TRST_N(TRST_N), .TDO(TDO), .TDO_OE(TDO_OE), .VCC_RESET_FORCE(VCC_RESET_FORCE),
    .VTR_POR_FORCE(VTR_POR_FORCE), .CPU_RESET_REQ(CPU_RESET_REQ),
    .CPU_RESET_OUT(CPU_RESET_OUT), .CPU_RESET_SHORTEN(CPU_RESET_SHORTEN),
    .PIN_CHAIN_IN(PIN_CHAIN_IN), .PIN_FUNC_DISCONNECT(PIN_FUNC_DISCONNECT),
    .PIN_CHAIN_RESULT_PIN(PIN_CHAIN_RESULT_PIN), .PIN_CHAIN_RESULT_OE(PIN_CHAIN_RESULT_OE)
  );

  jtd_host_model jtd_host_model_i (
    .clk(SYS_CLK), .tck(TCK), .tms(TMS), .tdi(TDI), .tdo(TDO), .tdo_oe(TDO_OE)
  );

  // System clock, 100 ns period
  initial
  begin
    SYS_CLK = 1'b0;
    forever #50 SYS_CLK = ~SYS_CLK;
  end

  task automatic chk_bit(input string what, input logic got, input logic want);
    comparisons++;
    if (got !== want)
    begin
      errors++;
      $display("wrong value at %0t ns: %s got %b expected %b", $time, what, got, want);
    end
  endtask : chk_bit

  task automatic chk_word(input string what, input logic [31:0] got, input logic [31:0] want);
    comparisons++;
    if (got !== want)
    begin
      errors++;
      $display("wrong value at %0t ns: %s got %h expected %h", $time, what, got, want);
    end
  endtask : chk_word

  task automatic ir(input logic [3:0] code);
    jtd_host_model_i.scan(1'b1, {36'h0, code}, 4, d);
  endtask : ir

  task automatic dr(input logic [31:0] din, input int n);
    jtd_host_model_i.scan(1'b0, {8'h0, din}, n, d);
  endtask : dr

  // Pulse the processor reset request and count the stretched cycles
  task automatic stretch(input int len, input string what);
    int cnt;
    cnt = 0;
    CPU_RESET_REQ = 1'b1;
    @(negedge SYS_CLK);
    CPU_RESET_REQ = 1'b0;
    repeat (len + 20)
    begin
      @(negedge SYS_CLK);
      if (CPU_RESET_OUT === 1'b1)
        cnt++;
    end
    chk_bit(what, (cnt >= len) && (cnt <= len + 3), 1'b1);
  endtask : stretch

  task automatic finish_test();
    $display("Comparisons %0d, errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : finish_test

  // Watchdog against a hung handshake
  initial
  begin
    repeat (80000) @(posedge SYS_CLK);
    errors++;
    $display("wrong value at %0t ns: watchdog expired", $time);
    finish_test();
  end

  // Main sequence
  initial
  begin
    SYS_RST = 1'b1;
    CE = 1'b1;
    TRST_N = 1'b1;
    CPU_RESET_REQ = 1'b0;
    PIN_CHAIN_IN = 8'h00;
    repeat (12) @(negedge SYS_CLK);
    SYS_RST = 1'b0;
    repeat (6) @(negedge SYS_CLK);
    chk_bit("oe idle", TDO_OE, 1'b0);
    jtd_host_model_i.discover(d);
    chk_word("idcode", d[31:0], jtd_pkg::IDCODE_VALUE);
    chk_bit("id start", d[0], 1'b1);
    chk_bit("id low", d[11:0] !== 12'h0ff, 1'b1);
    chk_word("chain end", {24'h0, d[39:32]}, 32'h0000_00ff);
    chk_bit("oe shift", jtd_host_model_i.shift_oe, 1'b1);
    // Bypass and an unimplemented code both give one cell of zero
    for (int k = 0; k < 2; k++)
    begin
      ir(k == 0 ? jtd_pkg::IR_BYPASS : 4'h5);
      chk_word("ir capture", {28'h0, d[3:0]}, 32'h0000_0001);
      dr(32'h0000_0005, 4);
      chk_word("bypass", {28'h0, d[3:0]}, 32'h0000_000a);
    end
    // Reset control register: default, read-only bits
    ir(jtd_pkg::IR_RESET_CTRL);
    dr(32'hffff_ffff, 32);
    chk_word("rc reset", d[31:0], 32'h0000_0000);
    dr(32'h0000_0000, 32);
    chk_word("rc readback", d[31:0], 32'hffff_e3ff);
    // Every combination of enable and the two forcing bits
    for (int i = 0; i < 8; i++)
    begin
      v = i[2:0];
      dr({28'h0, v, 1'b0}, 32);
      repeat (3) @(negedge SYS_CLK);
      chk_bit("vcc force", VCC_RESET_FORCE, v[2] & ~v[0]);
      chk_bit("vtr force", VTR_POR_FORCE, v[2] & ~v[1]);
    end
    dr(32'h0000_0008, 32);
    repeat (3) @(negedge SYS_CLK);
    chk_bit("vcc forced", VCC_RESET_FORCE, 1'b1);
    // Test reset clears the register and reselects identification
    TRST_N = 1'b0;
    repeat (6) @(negedge SYS_CLK);
    TRST_N = 1'b1;
    repeat (6) @(negedge SYS_CLK);
    chk_bit("vcc after trst", VCC_RESET_FORCE, 1'b0);
    chk_bit("vtr after trst", VTR_POR_FORCE, 1'b0);
    dr(32'h0000_0000, 32);
    chk_word("id after trst", d[31:0], jtd_pkg::IDCODE_VALUE);
    // Second register: default, read-only upper and middle bits, fast reset
    ir(jtd_pkg::IR_SHORTEN);
    dr(32'hffff_fffd, 32);
    chk_word("sh reset", d[31:0], 32'h0000_0000);
    dr(32'h0000_0001, 32);
    chk_word("sh readback", d[31:0], 32'h003f_cf1d);
    chk_bit("shorten on", CPU_RESET_SHORTEN, 1'b1);
    chk_bit("no chain yet", PIN_FUNC_DISCONNECT, 1'b0);
    stretch(SHORT, "short reset");
    dr(32'h0000_0000, 32);
    chk_bit("shorten off", CPU_RESET_SHORTEN, 1'b0);
    stretch(STRETCH, "full reset");
    // Pin-contact chain: enter, toggle pins one at a time
    dr(32'h0000_0002, 32);
    repeat (3) @(negedge SYS_CLK);
    chk_bit("disconnect", PIN_FUNC_DISCONNECT, 1'b1);
    chk_bit("result oe", PIN_CHAIN_RESULT_OE, 1'b1);
    chk_bit("result init", PIN_CHAIN_RESULT_PIN, 1'b1);
    exp = 1'b1;
    for (int k = 0; k < 16; k++)
    begin
      idx = k < 8 ? 7 - k : k - 8;
      PIN_CHAIN_IN[idx] = ~PIN_CHAIN_IN[idx];
      exp = ~exp;
      repeat (8) @(negedge SYS_CLK);
      chk_bit("result toggle", PIN_CHAIN_RESULT_PIN, exp);
    end
    // Clock enable low freezes the result; it follows once enabled again
    CE = 1'b0;
    PIN_CHAIN_IN[0] = 1'b1;
    repeat (8) @(negedge SYS_CLK);
    chk_bit("result frozen", PIN_CHAIN_RESULT_PIN, exp);
    CE = 1'b1;
    repeat (8) @(negedge SYS_CLK);
    chk_bit("result thawed", PIN_CHAIN_RESULT_PIN, ~exp);
    // Clearing the enable through the port has no effect; only power cycle leaves
    dr(32'h0000_0000, 32);
    chk_bit("still chain", PIN_FUNC_DISCONNECT, 1'b1);
    chk_bit("port silent", jtd_host_model_i.shift_oe, 1'b0);
    SYS_RST = 1'b1;
    repeat (2) @(negedge SYS_CLK);
    SYS_RST = 1'b0;
    repeat (2) @(negedge SYS_CLK);
    chk_bit("chain left", PIN_FUNC_DISCONNECT, 1'b0);
    finish_test();
  end
endmodule : tb_jtd_core
